// >>> scfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Upper straps captured at reset release edge.
// - Lower straps captured at reset release edge.
// - Board config word is read-only strap data.
// - Board config word read at fixed address.
// - Board type field returns fixed code.
// - Clock speed field uses documented encoding.
// - External cache field always reads ones.
// - Processor status fields use documented encoding.
// - Address decode and access control provided.
module scfg_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Strap data lines, sampled on the first clock after reset falls
  input wire logic [31:0] upper_straps,
  input wire logic [31:0] lower_straps,
  // Avalon-MM slave
  input wire logic [31:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Decoded fields of the board word
  output logic [3:0] clock_speed_code,
  output logic clock_speed_valid,
  output logic [3:0] cpu0_slot_status,
  output logic [3:0] cpu1_slot_status
);

  // ==========================================================================
  // Strap capture
  scfg_pkg::scfg_straps_t straps;
  scfg_pkg::scfg_straps_t next_straps;
  logic rst_d;
  logic captured;
  logic next_captured;

  // Capture on the first clock after reset falls; the pins are plain
  // synchronous inputs so no synchroniser is needed here
  always_comb begin
    next_straps = straps;
    next_captured = captured;
    if (rst) begin
      next_captured = 1'b0;
    end else if (rst_d && !captured) begin
      next_straps.upper = upper_straps;
      next_straps.lower = lower_straps;
      next_captured = 1'b1;
    end
  end

  // Registers hold straps until the next reset; reset never loads a port
  always_ff @(posedge clk) begin
    rst_d <= rst;
    captured <= next_captured;
    if (rst) begin
      straps <= '{upper: scfg_pkg::STRAP_RESET_VALUE, lower: scfg_pkg::STRAP_RESET_VALUE};
    end else begin
      straps <= next_straps;
    end
  end

  // ==========================================================================
  // Board word assembly
  logic [31:0] board_word;

  // Hardwired fields override straps so software always sees fixed values
  always_comb begin
    board_word = straps.upper;
    board_word[scfg_pkg::BOARD_TYPE_LSB +: 8] = scfg_pkg::BOARD_TYPE_CODE;
    board_word[scfg_pkg::EXT_CACHE_LSB +: 4] = scfg_pkg::EXT_CACHE_NONE;
  end

  // ==========================================================================
  // Bus slave
  typedef enum logic [1:0] {SCFG_IDLE, SCFG_ANSWER} scfg_state_t;
  scfg_state_t state;
  scfg_state_t next_state;
  logic [31:0] next_readdata;
  logic next_waitrequest;

  // One wait cycle per access: the answer is formed from registered data
  always_comb begin
    next_state = state;
    next_readdata = readdata;
    next_waitrequest = 1'b1;
    case (state)
      SCFG_IDLE: begin
        if (read || write) begin
          next_state = SCFG_ANSWER;
          next_waitrequest = 1'b0;
          if (read) begin
            if (address == scfg_pkg::BOARD_CONFIG_STATUS_ADDR) begin
              next_readdata = board_word;
            end else if (address == scfg_pkg::MEMORY_CONFIG_STATUS_ADDR) begin
              next_readdata = straps.lower;
            end else begin
              next_readdata = scfg_pkg::UNMAPPED_READ_VALUE;
            end
          end
          // Writes complete but store nothing anywhere
        end
      end
      SCFG_ANSWER: begin
        next_state = SCFG_IDLE;
      end
      default: begin
        next_state = SCFG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SCFG_IDLE;
      readdata <= scfg_pkg::UNMAPPED_READ_VALUE;
      waitrequest <= 1'b1;
    end else begin
      state <= next_state;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
    end
  end

  // ==========================================================================
  // Field decode outputs
  logic [3:0] next_clk_code;
  logic next_clk_valid;

  // Codes below the first valid one are reserved and flagged invalid
  always_comb begin
    next_clk_code = board_word[scfg_pkg::CLOCK_SPEED_LSB +: 4];
    case (next_clk_code)
      scfg_pkg::CLK_50_25, scfg_pkg::CLK_60_30, scfg_pkg::CLK_66_33: begin
        next_clk_valid = 1'b1;
      end
      default: begin
        next_clk_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_speed_code <= 4'hf;
      clock_speed_valid <= 1'b0;
      cpu0_slot_status <= 4'hf;
      cpu1_slot_status <= 4'hf;
    end else begin
      clock_speed_code <= next_clk_code;
      clock_speed_valid <= next_clk_valid;
      cpu0_slot_status <= board_word[scfg_pkg::CPU0_STATUS_LSB +: 4];
      cpu1_slot_status <= board_word[scfg_pkg::CPU1_STATUS_LSB +: 4];
    end
  end

  logic unused_ok;
  assign unused_ok = ^{writedata, byteenable};

endmodule // scfg_regs
`default_nettype wire

// >>> scfg_pkg.sv
package scfg_pkg;

  // ==========================================================================
  // Register map (byte addresses within the system register space)
  localparam logic [31:0] BOARD_CONFIG_STATUS_ADDR = 32'hfef80400;
  localparam logic [31:0] MEMORY_CONFIG_STATUS_ADDR = 32'hfef80404;
  localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;

  // ==========================================================================
  // Field layout of the board configuration word (bit 0 is the MSB in the
  // big-endian numbering, so field positions here are little-endian indices)
  localparam int BOARD_TYPE_LSB = 24;
  localparam int CLOCK_SPEED_LSB = 20;
  localparam int EXT_CACHE_LSB = 16;
  localparam int CPU0_STATUS_LSB = 12;
  localparam int CPU1_STATUS_LSB = 8;

  // Hardwired field values; identification code is arbitrary
  localparam logic [7:0] BOARD_TYPE_CODE = 8'h5a;
  localparam logic [3:0] EXT_CACHE_NONE = 4'hf;

  // Clock speed encodings
  localparam logic [3:0] CLK_50_25 = 4'hd;
  localparam logic [3:0] CLK_60_30 = 4'he;
  localparam logic [3:0] CLK_66_33 = 4'hf;

  // Processor slot status encodings
  localparam logic [3:0] CPU_PRESENT_1M = 4'h4;
  localparam logic [3:0] CPU_PRESENT_512K = 4'h5;
  localparam logic [3:0] CPU_PRESENT_256K = 4'h6;
  localparam logic [3:0] CPU_PRESENT_NONE = 4'h7;
  localparam logic [3:0] CPU_ABSENT_MIN = 4'h8;

  // Reset value of captured words: all ones, as undriven pull-ups read
  localparam logic [31:0] STRAP_RESET_VALUE = 32'hffffffff;

  // Bus slave answer packed together
  typedef struct packed {
    logic [31:0] readdata;
    logic readdatavalid;
    logic waitrequest;
  } scfg_resp_t;

  // Strap pins of both controllers
  typedef struct packed {
    logic [31:0] upper;
    logic [31:0] lower;
  } scfg_straps_t;

endpackage

// >>> scfg_board.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Board strap network
module scfg_board (
  // Fitted pull-down per line, upper word first
  input wire logic [63:0] pull_down,
  // Levels seen at both controllers, upper word first
  output var logic [63:0] levels
);
  // Weak pull-up reads one unless a pull-down is fitted
  assign levels = ~pull_down;
endmodule // scfg_board
`default_nettype wire

// >>> scfg_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bus timing and strap capture checks
module scfg_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Straps and bus
  input wire logic [31:0] upper_straps,
  input wire logic [31:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Decoded fields
  input wire logic [3:0] clock_speed_code,
  input wire logic clock_speed_valid,
  input wire logic [3:0] cpu0_slot_status,
  input wire logic [3:0] cpu1_slot_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Read answers by target
  wire logic ans = read && !waitrequest;
  wire logic brd = address == scfg_pkg::BOARD_CONFIG_STATUS_ADDR;
  wire logic unm = !brd && address != scfg_pkg::MEMORY_CONFIG_STATUS_ADDR;
  wait_one_a: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("answer held too long");
  answer_time_a: assert property ($rose(read || write) |=> !waitrequest)
    else $error("answer not after one wait state");
  board_id_a: assert property (ans && brd |-> readdata[31:24] == scfg_pkg::BOARD_TYPE_CODE)
    else $error("board code wrong");
  cache_none_a: assert property (ans && brd |-> readdata[19:16] == scfg_pkg::EXT_CACHE_NONE)
    else $error("cache field wrong");
  board_fields_a: assert property (ans && brd |-> readdata[23:8] == {clock_speed_code, 4'hf, cpu0_slot_status, cpu1_slot_status})
    else $error("fields disagree");
  unmapped_zero_a: assert property (ans && unm |-> readdata == scfg_pkg::UNMAPPED_READ_VALUE)
    else $error("unmapped read not zero");
  speed_valid_a: assert property (!$past(rst, 3) |-> clock_speed_valid == (clock_speed_code >= 4'hd))
    else $error("speed valid wrong");
  strap_stable_a: assert property (!$past(rst, 3) |-> $stable({clock_speed_code, cpu0_slot_status}))
    else $error("captured field moved");
  strap_capture_a: assert property ($past(rst, 4) && !$past(rst, 3) |-> cpu1_slot_status == $past(upper_straps[11:8], 3))
    else $error("capture wrong");
endmodule // scfg_props
bind scfg_regs scfg_props u_scfg_props (.clk, .rst, .upper_straps, .address, .read, .write, .readdata, .waitrequest,
  .clock_speed_code, .clock_speed_valid, .cpu0_slot_status, .cpu1_slot_status);
`default_nettype wire

// >>> strap_config_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Strap capture and register bench
module strap_config_registers_tb;
  logic clk = 0, rst = 1, read = 0, write = 0, waitrequest, clock_speed_valid;
  logic [31:0] address = 0, wdata = 0, rdata, readdata;
  logic [63:0] pd = 0;
  logic [3:0] clock_speed_code, cpu0_slot_status, cpu1_slot_status;
  scfg_pkg::scfg_straps_t straps;
  int n_errors = 0, compares = 0;
  // Clock of 20 ns
  initial forever #10 clk = ~clk;
  scfg_board u_scfg_board (.pull_down(pd), .levels(straps));
  scfg_regs u_scfg_regs (.clk, .rst, .upper_straps(straps.upper), .lower_straps(straps.lower), .address, .read,
    .write, .writedata(wdata), .byteenable(4'hf), .readdata, .waitrequest, .clock_speed_code, .clock_speed_valid,
    .cpu0_slot_status, .cpu1_slot_status);
  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One access held until waitrequest is sampled low at a rising edge; the
  // request drops at that edge and one idle edge follows
  task automatic bus(logic wr, logic [31:0] a);
    int k;
    read <= !wr;
    write <= wr;
    address <= a;
    wdata <= $urandom;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      n_errors++;
      end_sim();
    end
    rdata = readdata;
    read <= 0;
    write <= 0;
    @(posedge clk);
  endtask
  // Expected words built from the chosen straps
  initial begin
    logic [31:0] up, lo, ex;
    void'($urandom(32'h9320));
    for (int i = 0; i < 4; i++) begin
      up = $urandom;
      up[23:20] = (i < 3) ? 4'hd + i : $urandom_range(12, 0);
      up[15:12] = 4 + i;
      up[11:8] = 8 + 2 * i;
      lo = $urandom;
      ex = {scfg_pkg::BOARD_TYPE_CODE, up[23:20], scfg_pkg::EXT_CACHE_NONE, up[15:0]};
      pd <= {~up, ~lo};
      rst <= 1;
      repeat (8) @(posedge clk);
      rst <= 0;
      repeat (3) @(posedge clk);
      pd <= $urandom;
      bus(0, scfg_pkg::BOARD_CONFIG_STATUS_ADDR);
      chk("board word", ex, rdata);
      chk("speed", {i < 3, up[23:20]}, {clock_speed_valid, clock_speed_code});
      chk("slots", up[15:8], {cpu0_slot_status, cpu1_slot_status});
      bus(0, scfg_pkg::MEMORY_CONFIG_STATUS_ADDR);
      chk("memory word", lo, rdata);
      bus(1, scfg_pkg::BOARD_CONFIG_STATUS_ADDR);
      bus(1, scfg_pkg::MEMORY_CONFIG_STATUS_ADDR);
      bus(0, scfg_pkg::BOARD_CONFIG_STATUS_ADDR);
      chk("after write", ex, rdata);
      bus(0, scfg_pkg::MEMORY_CONFIG_STATUS_ADDR);
      chk("memory kept", lo, rdata);
      bus(0, 32'hfef80408 + 4 * i);
      chk("unmapped", scfg_pkg::UNMAPPED_READ_VALUE, rdata);
      $display("test %0d done", i);
    end
    end_sim();
  end
endmodule // strap_config_registers_tb
`default_nettype wire
